// File: shared/slhb_pkg.sv
`default_nettype none
package slhb_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // timing: one half-second tick drives every slow rate
   localparam int CLK_KHZ = 50000;
   localparam int FLASH_PERIOD_MS = 1000;
   localparam int HALF_TICK_CYC = CLK_KHZ * FLASH_PERIOD_MS / 2;
   localparam int TICKS_PER_S = 2;
   localparam int WINDOW_S = 60;
   localparam int SURVEY_HOLD_S = 3;
   localparam int DEFAULT_HOLD_S = 10;
   localparam logic [6:0] WINDOW_TICKS = 7'(WINDOW_S * TICKS_PER_S);
   localparam logic [4:0] SURVEY_TICKS = 5'(SURVEY_HOLD_S * TICKS_PER_S);
   localparam logic [4:0] DEFAULT_TICKS = 5'(DEFAULT_HOLD_S * TICKS_PER_S);
   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_NET_ID = 12'h004;
   localparam logic [11:0] ADDR_CHAN = 12'h008;
   localparam logic [11:0] ADDR_POLL = 12'h00C;
   localparam logic [11:0] ADDR_PERIOD = 12'h010;
   localparam logic [11:0] ADDR_SERIAL = 12'h014;
   localparam logic [11:0] ADDR_STATUS = 12'h018;
   localparam logic [11:0] ADDR_TEMP = 12'h01C;
   localparam int CTRL_REPEATER_BIT = 0;
   localparam int STAT_SURVEY_BIT = 4;
   localparam int STAT_BTN_BIT = 5;
   localparam logic [7:0] POLL_MIN = 8'h01;
   localparam logic [7:0] POLL_MAX = 8'h37;
   localparam logic [15:0] TEMP_ERR_VAL = 16'hFFFF;
   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic repeater;
      logic [15:0] net_id;
      logic [7:0] channel;
      logic [7:0] poll_slot;
      logic [15:0] comm_period;
   } slhb_cfg_t;
   localparam slhb_cfg_t CFG_DEFAULT = '{repeater: 1'b0, net_id: 16'h0001,
      channel: 8'h01, poll_slot: 8'h01, comm_period: 16'h003C};
   typedef struct packed {
      logic red;
      logic green;
      logic [3:0] blue;
   } slhb_led_t;
   typedef enum logic [2:0] {
      NET_CONFIG = 3'h0,
      NET_TRY = 3'h1,
      NET_CONN = 3'h3,
      NET_SLEEP = 3'h2,
      NET_DISC = 3'h6
   } slhb_net_t;
   typedef enum logic [1:0] {
      BTN_IDLE = 2'h0,
      BTN_HOLD = 2'h1,
      BTN_LONG = 2'h3,
      BTN_WAIT = 2'h2
   } slhb_btn_t;
endpackage : slhb_pkg
`default_nettype wire

// File: design/slhb_tick.sv
`timescale 1ns/10ps
`default_nettype none
module slhb_tick #(
   parameter int CYC = slhb_pkg::HALF_TICK_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // control
   input wire logic clear,
   // one-cycle enable every CYC cycles
   output logic tick
);
   localparam int W = $clog2(CYC);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } slhb_div_t;
   slhb_div_t q;
   slhb_div_t next_q;

   always_comb begin
      next_q = q;
      next_q.tick = 1'b0;
      if (clear) begin
         next_q.cnt = '0;
      end else if (q.cnt == W'(CYC - 1)) begin
         next_q.cnt = '0;
         next_q.tick = 1'b1;
      end else begin
         next_q.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick = q.tick;
endmodule : slhb_tick
`default_nettype wire

// File: design/slhb_status_ctrl.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module slhb_status_ctrl #(
   parameter int HALF_TICK = slhb_pkg::HALF_TICK_CYC,
   // arbitrary value, replace per unit
   parameter logic [31:0] SERIAL_NUM = 32'h0000_1234
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // radio and sensor side
   input wire slhb_pkg::slhb_net_t net_state,
   input wire logic [2:0] rssi_level,
   input wire logic [15:0] temp_raw,
   input wire logic temp_err,
   output slhb_pkg::slhb_cfg_t cfg,
   output logic site_survey,
   output logic factory_load,
   // front panel
   input wire logic test_btn_n,
   output logic led_red,
   output logic led_green,
   output logic [3:0] led_blue
);
   import slhb_pkg::*;

   typedef struct packed {
      slhb_cfg_t cfg;
      logic [1:0] btn_sync;
      slhb_btn_t btn;
      logic [4:0] hold;
      logic survey;
      logic blink;
      slhb_net_t net_prev;
      logic win;
      logic [6:0] win_cnt;
      slhb_led_t led;
      logic load_dflt;
      logic [31:0] rdata;
      logic err;
   } slhb_st_t;

   slhb_st_t q;
   slhb_st_t n;
   logic blink_tick;
   logic btn_tick;
   logic pressed;
   logic setup;
   logic access;

   function automatic logic [3:0] rssi_bar(input logic [2:0] lvl);
      rssi_bar = (lvl >= 3'h4) ? 4'hF : 4'((5'h01 << lvl) - 5'h01);
   endfunction : rssi_bar

   ////////////////////////////////////////////////////////////////////////////
   // timebases: free one for flashing, one restarted at each press

   slhb_tick #(.CYC(HALF_TICK)) u_blink_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(1'b0),
      .tick(blink_tick)
   );

   // restarted so a hold is timed from the press itself
   slhb_tick #(.CYC(HALF_TICK)) u_btn_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clear(q.btn == BTN_IDLE),
      .tick(btn_tick)
   );

   assign pressed = ~q.btn_sync[1];
   assign setup = psel & ~penable;
   assign access = psel & penable;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = q;
      n.btn_sync = {q.btn_sync[0], test_btn_n};
      n.load_dflt = 1'b0;
      if (blink_tick) begin
         n.blink = ~q.blink;
      end

      // button hold timing, counted in half seconds
      unique case (q.btn)
         BTN_IDLE: begin
            if (pressed) begin
               n.btn = BTN_HOLD;
               n.hold = '0;
            end
         end
         BTN_HOLD: begin
            if (!pressed) begin
               n.btn = BTN_IDLE;
            end else if (btn_tick) begin
               n.hold = q.hold + 5'h01;
               if (n.hold == SURVEY_TICKS) begin
                  n.survey = ~q.survey;
                  n.btn = BTN_LONG;
               end
            end
         end
         BTN_LONG: begin
            if (!pressed) begin
               n.btn = BTN_IDLE;
            end else if (btn_tick) begin
               n.hold = q.hold + 5'h01;
               if (n.hold == DEFAULT_TICKS) begin
                  n.load_dflt = 1'b1;
                  n.survey = 1'b0;
                  n.btn = BTN_WAIT;
               end
            end
         end
         BTN_WAIT: begin
            // no repeat action until the button is let go
            if (!pressed) begin
               n.btn = BTN_IDLE;
            end
         end
      endcase

      // one-minute window opened on entry to connected or disconnected
      n.net_prev = net_state;
      if (net_state != q.net_prev && (net_state == NET_CONN || net_state == NET_DISC)) begin
         n.win = 1'b1;
         n.win_cnt = '0;
      end else if (q.win && blink_tick) begin
         n.win_cnt = q.win_cnt + 7'h01;
         if (n.win_cnt == WINDOW_TICKS) begin
            n.win = 1'b0;
         end
      end

      // indicator pattern, from the updated phase so it lands with the flip
      n.led = '0;
      if (n.survey) begin
         n.led.blue = rssi_bar(rssi_level);
      end else begin
         unique case (net_state)
            NET_CONFIG: begin
               n.led.red = 1'b1;
               n.led.green = 1'b1;
               n.led.blue = {4{n.blink}};
            end
            NET_TRY: begin
               n.led.red = n.blink;
            end
            NET_CONN, NET_SLEEP: begin
               if (q.cfg.repeater || (net_state == NET_CONN && n.win)) begin
                  n.led.red = n.blink;
                  n.led.green = ~n.blink;
               end
            end
            NET_DISC: begin
               n.led.red = n.win & n.blink;
            end
            default: begin
            end
         endcase
      end

      // apb: decode and read data in setup, write in access
      if (setup) begin
         n.err = 1'b0;
         n.rdata = '0;
         unique case (paddr)
            ADDR_CTRL: n.rdata[CTRL_REPEATER_BIT] = q.cfg.repeater;
            ADDR_NET_ID: n.rdata[15:0] = q.cfg.net_id;
            ADDR_CHAN: n.rdata[7:0] = q.cfg.channel;
            ADDR_POLL: begin
               n.rdata[7:0] = q.cfg.poll_slot;
               if (pwrite && (pwdata < {24'h0, POLL_MIN} || pwdata > {24'h0, POLL_MAX})) begin
                  n.err = 1'b1;
               end
            end
            ADDR_PERIOD: n.rdata[15:0] = q.cfg.comm_period;
            ADDR_SERIAL: begin
               n.rdata = SERIAL_NUM;
               n.err = pwrite;
            end
            ADDR_STATUS: begin
               n.rdata[2:0] = net_state;
               n.rdata[STAT_SURVEY_BIT] = q.survey;
               n.rdata[STAT_BTN_BIT] = pressed;
               n.err = pwrite;
            end
            ADDR_TEMP: begin
               n.rdata[15:0] = temp_err ? TEMP_ERR_VAL : temp_raw;
               n.err = pwrite;
            end
            default: n.err = 1'b1;
         endcase
      end else if (access && pwrite && !q.err) begin
         unique case (paddr)
            ADDR_CTRL: n.cfg.repeater = pwdata[CTRL_REPEATER_BIT];
            ADDR_NET_ID: n.cfg.net_id = pwdata[15:0];
            ADDR_CHAN: n.cfg.channel = pwdata[7:0];
            ADDR_POLL: n.cfg.poll_slot = pwdata[7:0];
            ADDR_PERIOD: n.cfg.comm_period = pwdata[15:0];
            default: begin
            end
         endcase
      end

      // defaults win over a write in the same cycle
      if (n.load_dflt) begin
         n.cfg = CFG_DEFAULT;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.cfg <= CFG_DEFAULT;
         q.btn_sync <= 2'b11;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = q.rdata;
   assign pready = access;
   assign pslverr = access & q.err;
   // identifier and channel go to the radio as set
   assign cfg = q.cfg;
   assign site_survey = q.survey;
   assign factory_load = q.load_dflt;
   assign led_red = q.led.red;
   assign led_green = q.led.green;
   assign led_blue = q.led.blue;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_cfg_steady;
      net_state == NET_CONFIG && !n.survey;
   endsequence
   sequence s_hold_3s;
      q.btn == BTN_HOLD && pressed && btn_tick && q.hold == SURVEY_TICKS - 5'h01;
   endsequence
   sequence s_hold_10s;
      q.btn == BTN_LONG && pressed && btn_tick && q.hold == DEFAULT_TICKS - 5'h01;
   endsequence

   property p_cfg_blink;
      s_cfg_steady ##1 (s_cfg_steady and blink_tick) |=>
         led_blue == ~$past(led_blue) && (led_blue == 4'hF || led_blue == 4'h0);
   endproperty
   a_cfg_blink: assert property (p_cfg_blink) else $error("blue group not flashing");

   property p_conn_entry;
      net_state == NET_CONN && q.net_prev != NET_CONN && !n.survey |=> led_red != led_green;
   endproperty
   a_conn_entry: assert property (p_conn_entry) else $error("no alternation on connect");

   property p_conn_off;
      !q.cfg.repeater && net_state == NET_CONN && q.net_prev == NET_CONN && !q.win
         && !n.survey |=> !led_red && !led_green;
   endproperty
   a_conn_off: assert property (p_conn_off) else $error("connect lights not off");

   property p_rep_hold;
      q.cfg.repeater && (net_state == NET_CONN || net_state == NET_SLEEP) && !n.survey
         |=> led_red != led_green;
   endproperty
   a_rep_hold: assert property (p_rep_hold) else $error("repeater lights timed out");

   property p_try;
      net_state == NET_TRY && !n.survey |=> !led_green && led_blue == 4'h0;
   endproperty
   a_try: assert property (p_try) else $error("wrong lights while trying");

   property p_disc_end;
      net_state == NET_DISC && q.net_prev == NET_DISC && !q.win && !n.survey |=> !led_red;
   endproperty
   a_disc_end: assert property (p_disc_end) else $error("retry blink past window");

   property p_survey_bar;
      n.survey |=> led_blue == rssi_bar($past(rssi_level));
   endproperty
   a_survey_bar: assert property (p_survey_bar) else $error("survey bar mismatch");

   property p_survey_toggle;
      s_hold_3s |=> site_survey != $past(site_survey);
   endproperty
   a_survey_toggle: assert property (p_survey_toggle) else $error("3 s hold no toggle");

   property p_survey_exit;
      s_hold_3s and site_survey |=> !site_survey ##1 !site_survey;
   endproperty
   a_survey_exit: assert property (p_survey_exit) else $error("survey not left");

   property p_dflt;
      s_hold_10s |=> factory_load && cfg == CFG_DEFAULT ##1 !factory_load;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults not loaded");

   property p_poll_range;
      access && pwrite && paddr == ADDR_POLL && !n.load_dflt
         && (pwdata[7:0] == 8'h00 || pwdata > {24'h0, POLL_MAX})
         |=> cfg.poll_slot == $past(cfg.poll_slot);
   endproperty
   a_poll_range: assert property (p_poll_range) else $error("bad poll slot taken");

   property p_temp_err;
      setup && !pwrite && paddr == ADDR_TEMP && temp_err |=> prdata == 32'h0000_FFFF;
   endproperty
   a_temp_err: assert property (p_temp_err) else $error("sensor error not 65535");

   property p_serial_ro;
      setup && pwrite && paddr == ADDR_SERIAL |=> pslverr && prdata == SERIAL_NUM;
   endproperty
   a_serial_ro: assert property (p_serial_ro) else $error("serial write accepted");

   property p_mode;
      access && pwrite && paddr == ADDR_CTRL && !n.load_dflt
         |=> cfg.repeater == $past(pwdata[CTRL_REPEATER_BIT]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bit not stored");
endmodule : slhb_status_ctrl
`default_nettype wire

// File: test/slhb_partner.sv
`timescale 1ns/10ps
`default_nettype none
module slhb_partner (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // commands from the bench
   input wire slhb_pkg::slhb_net_t net_req,
   input wire logic [2:0] rssi_req,
   input wire logic [15:0] temp_req,
   input wire logic terr_req,
   input wire logic hold_go,
   input wire logic [15:0] hold_cyc,
   // toward the block
   output slhb_pkg::slhb_net_t net_state,
   output logic [2:0] rssi_level,
   output logic [15:0] temp_raw,
   output logic temp_err,
   output logic test_btn_n,
   output logic busy
);
   import slhb_pkg::*;
   logic [15:0] left_cyc;
   assign busy = (left_cyc != 16'h0000);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         net_state <= NET_CONFIG;
         rssi_level <= 3'h0;
         temp_raw <= 16'h0000;
         temp_err <= 1'b0;
         test_btn_n <= 1'b1;
         left_cyc <= 16'h0000;
      end else begin
         net_state <= net_req;
         rssi_level <= rssi_req;
         // a faulted sensor inverts its last value each cycle, so every other cycle is the clean one
         temp_raw <= terr_req ? ~temp_raw : temp_req;
         temp_err <= terr_req;
         if (hold_go) begin
            left_cyc <= hold_cyc;
         end else if (left_cyc != 16'h0000) begin
            left_cyc <= left_cyc - 16'h0001;
         end
         test_btn_n <= !(hold_go || left_cyc > 16'h0001);
      end
   end
endmodule : slhb_partner
`default_nettype wire

// File: test/slhb_status_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module slhb_status_ctrl_tb_top;
   import slhb_pkg::*;
   localparam int HT = 4;
   localparam int WIN = 120 * HT;
   // arbitrary value
   localparam logic [31:0] SER = 32'h0000_0A5C;
   logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, temp_err, busy, test_btn_n, site_survey, factory_load;
   logic terr_req = 1'b0, hold_go = 1'b0, led_red, led_green;
   slhb_net_t net_req = NET_CONFIG, net_state;
   logic [2:0] rssi_req = 3'h0, rssi_level;
   logic [15:0] temp_req = 16'h0000, hold_cyc = 16'h0000, temp_raw;
   logic [3:0] led_blue, exp_b;
   slhb_cfg_t cfg;
   int error_cnt = 0, n_compared = 0, fl_cnt = 0, r_on, g_on, rg_eq, b_hit, b_zero, k;
   slhb_status_ctrl #(.HALF_TICK(HT), .SERIAL_NUM(SER)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .net_state(net_state),
      .rssi_level(rssi_level), .temp_raw(temp_raw), .temp_err(temp_err), .cfg(cfg),
      .site_survey(site_survey), .factory_load(factory_load), .test_btn_n(test_btn_n),
      .led_red(led_red), .led_green(led_green), .led_blue(led_blue));
   slhb_partner i_partner (.ref_clk(ref_clk), .nrst(nrst), .net_req(net_req),
      .rssi_req(rssi_req), .temp_req(temp_req), .terr_req(terr_req), .hold_go(hold_go),
      .hold_cyc(hold_cyc), .net_state(net_state), .rssi_level(rssi_level),
      .temp_raw(temp_raw), .temp_err(temp_err), .test_btn_n(test_btn_n), .busy(busy));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (factory_load === 1'b1) fl_cnt <= fl_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_cnt(input int got, input int exp, input string what);
      n_compared++;
      if (got != exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s count %0d exp %0d", $time, what, got, exp);
      end
   endtask : cmp_cnt
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   // one apb transfer; read data only compared when no error is expected
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic e, input logic [31:0] x);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      cmp_word(32'(pslverr), 32'(e), "pslverr");
      if (!w && !e) cmp_word(prdata, x, "prdata");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : acc
   // apply a radio state, wait, then sample the leds for two blink periods
   task automatic led_case(input slhb_net_t s, input int pre, input int r, input int g,
         input int eq, input int bh, input int bz);
      @(posedge ref_clk);
      net_req <= s;
      repeat (pre) @(posedge ref_clk);
      r_on = 0;
      g_on = 0;
      rg_eq = 0;
      b_hit = 0;
      b_zero = 0;
      repeat (16) begin
         @(posedge ref_clk);
         r_on += (led_red === 1'b1);
         g_on += (led_green === 1'b1);
         rg_eq += (led_red === led_green);
         b_hit += (led_blue === exp_b);
         b_zero += (led_blue === 4'h0);
      end
      cmp_cnt(r_on, r, "red on");
      cmp_cnt(g_on, g, "green on");
      cmp_cnt(rg_eq, eq, "red equals green");
      cmp_cnt(b_hit, bh, "blue pattern");
      cmp_cnt(b_zero, bz, "blue off");
   endtask : led_case
   task automatic hold(input int n);
      @(posedge ref_clk);
      hold_cyc <= 16'(n);
      hold_go <= 1'b1;
      @(posedge ref_clk);
      hold_go <= 1'b0;
      // busy only shows from the edge after the partner takes the command
      do begin
         @(posedge ref_clk);
      end while (busy === 1'b1);
      repeat (8) @(posedge ref_clk);
   endtask : hold
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      acc(0, ADDR_CTRL, 0, 0, 32'h0000_0000);
      acc(0, ADDR_NET_ID, 0, 0, 32'h0000_0001);
      acc(0, ADDR_POLL, 0, 0, 32'h0000_0001);
      acc(0, ADDR_PERIOD, 0, 0, 32'h0000_003C);
      acc(1, ADDR_NET_ID, 32'h0000_BEEF, 0, 0);
      acc(1, ADDR_CHAN, 32'h0000_000F, 0, 0);
      acc(1, ADDR_PERIOD, 32'h0000_0078, 0, 0);
      acc(0, ADDR_PERIOD, 0, 0, 32'h0000_0078);
      // settings register on the access edge; look one edge later
      @(posedge ref_clk);
      cmp_word(32'(cfg.net_id), 32'h0000_BEEF, "cfg net id");
      cmp_word(32'(cfg.channel), 32'h0000_000F, "cfg channel");
      acc(1, ADDR_SERIAL, 32'hFFFF_FFFF, 1, 0);
      acc(0, ADDR_SERIAL, 0, 0, SER);
      acc(1, ADDR_STATUS, 0, 1, 0);
      acc(1, ADDR_TEMP, 0, 1, 0);
      acc(1, 12'h020, 0, 1, 0);
      acc(1, ADDR_POLL, 32'h0000_0000, 1, 0);
      acc(1, ADDR_POLL, 32'h0000_0038, 1, 0);
      acc(1, ADDR_POLL, 32'h0001_0037, 1, 0);
      acc(1, ADDR_POLL, 32'h0000_0037, 0, 0);
      acc(0, ADDR_POLL, 0, 0, 32'h0000_0037);
      temp_req <= 16'h1234;
      acc(0, ADDR_TEMP, 0, 0, 32'h0000_1234);
      terr_req <= 1'b1;
      acc(0, ADDR_TEMP, 0, 0, 32'h0000_FFFF);
      $display("test registers done");
      exp_b = 4'hF;
      led_case(NET_CONFIG, 3, 16, 16, 16, 8, 8);
      exp_b = 4'h0;
      led_case(NET_TRY, 3, 8, 0, 8, 16, 16);
      led_case(NET_CONN, 3, 8, 8, 0, 16, 16);
      led_case(NET_CONN, WIN, 0, 0, 16, 16, 16);
      led_case(NET_SLEEP, 3, 0, 0, 16, 16, 16);
      led_case(NET_DISC, 3, 8, 0, 8, 16, 16);
      led_case(NET_DISC, WIN, 0, 0, 16, 16, 16);
      acc(1, ADDR_CTRL, 32'h0000_0001, 0, 0);
      @(posedge ref_clk);
      cmp_word(32'(cfg.repeater), 32'h0000_0001, "cfg repeater");
      led_case(NET_TRY, 3, 8, 0, 8, 16, 16);
      led_case(NET_CONN, WIN + 20, 8, 8, 0, 16, 16);
      led_case(NET_SLEEP, 3, 8, 8, 0, 16, 16);
      acc(1, ADDR_CTRL, 32'h0000_0000, 0, 0);
      $display("test leds done");
      net_req <= NET_CONFIG;
      // too short a hold must not count
      hold(20);
      cmp_word(32'(site_survey), 32'h0000_0000, "survey short");
      hold(35);
      cmp_word(32'(site_survey), 32'h0000_0001, "survey on");
      for (int i = 0; i < 6; i++) begin
         exp_b = (i >= 4) ? 4'hF : 4'((1 << i) - 1);
         rssi_req <= 3'(i);
         led_case(NET_CONFIG, 3, 0, 0, 16, 16, (i == 0) ? 16 : 0);
      end
      acc(0, ADDR_STATUS, 0, 0, 32'h0000_0010);
      hold(35);
      cmp_word(32'(site_survey), 32'h0000_0000, "survey off");
      k = fl_cnt;
      hold(100);
      cmp_cnt(fl_cnt - k, 1, "default pulses");
      cmp_word(32'(site_survey), 32'h0000_0000, "survey after defaults");
      cmp_word(32'(cfg.net_id), 32'h0000_0001, "default net id");
      acc(0, ADDR_POLL, 0, 0, 32'h0000_0001);
      acc(0, ADDR_CHAN, 0, 0, 32'h0000_0001);
      acc(0, ADDR_PERIOD, 0, 0, 32'h0000_003C);
      $display("test button done");
      final_report();
   end
endmodule : slhb_status_ctrl_tb_top
`default_nettype wire
